// file: hw/shcp_port.sv
// Purpose: serial host command port, device side
// Assumes: serial clock far slower than clk; all pins are synchronised here
// Notes: command/write/read class follows address ranges; word size from core, except the fixed-size mask and status registers
//
// Behaviour
// [RULE_01] each transaction is one address byte, then one word, none or a stream
// [RULE_02] word size is a whole number of bytes chosen by the addressed register
// [RULE_03] address-only command transactions act when the address byte completes
// [RULE_04] command line bits are taken on rising serial clock edges
// [RULE_05] reply bit stays steady while the serial clock is high
// [RULE_06] host holds select low per transaction; select rising ends it
// [RULE_07] a written word may take up to 60 us to be picked up
// [RULE_08] streaming registers move several words through a FIFO per select
// [RULE_09] commands use only the first eight bits; address 01 resets the device
// [RULE_10] single-byte registers move only the first eight data bits
// [RULE_11] only one data line is active; the address sets the direction
// [RULE_12] serial clock may idle high or low around a transaction
// [RULE_13] gaps of any length or none between bytes are accepted
// [RULE_14] interrupt only for status bits whose mask bit is set
// [RULE_15] enabled status changes raise the interrupt; host reads status
// [RULE_16] host may poll the interrupt pin level instead of status
// [RULE_17] interrupt mask at address 1F, status at address 40
// [RULE_18] interrupt request is active-low open drain
// [RULE_19] reply line driven only in the data phase of a read
// [RULE_20] bits and bytes travel most significant first
`timescale 1ns/100ps
`include "shcp_cfg.svh"
module shcp_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic host_command_line,
  input wire logic select_n,
  output logic reply_data,
  output logic reply_oe_n,
  output logic irq_request_n,
  output logic irq_oe_n,
  output shcp_pkg::shcp_word_s core_wr_word,
  output logic core_wr_valid,
  input wire logic core_wr_ready,
  output logic [7:0] core_addr,
  input wire logic [1:0] core_nbytes,
  input wire logic core_stream,
  input wire logic [31:0] core_rd_data,
  output logic core_rd_take,
  output logic [7:0] cmd_code,
  output logic cmd_valid,
  output logic dev_reset,
  input wire logic [15:0] status_event
);
  import shcp_pkg::*;

  logic [2:0] sclk_s_ff;
  logic [1:0] cdat_s_ff;
  logic [2:0] sel_s_ff;
  shcp_state_e state_ff;
  shcp_state_e nxt_state;
  logic [4:0] bitcnt_ff;
  logic [4:0] nxt_bitcnt;
  logic [31:0] shift_ff;
  logic [31:0] nxt_shift;
  logic [7:0] addr_ff;
  logic [7:0] nxt_addr;
  logic [1:0] nb_ff;
  logic [1:0] nxt_nb;
  logic stream_ff;
  logic nxt_stream;
  logic rose_ff;
  logic nxt_rose;
  logic done_ff;
  logic nxt_done;
  logic reply_ff;
  logic reply_oe_n_ff;
  logic take_ff;
  logic cmd_valid_ff;
  logic [7:0] cmd_code_ff;
  logic dev_reset_ff;
  logic [15:0] mask_ff;
  logic [15:0] status_ff;
  logic [15:0] snap_ff;
  logic irq_n_ff;
  logic pend_valid_ff;
  shcp_word_s pend_ff;
  logic [11:0] lat_cnt_ff;
  logic fifo_in_ready;

  // edges are found on the second sync stage against the third
  wire sclk_rise = sclk_s_ff[1] & ~sclk_s_ff[2];
  wire sclk_fall = ~sclk_s_ff[1] & sclk_s_ff[2];
  wire sel_low = ~sel_s_ff[1];
  wire cbit = cdat_s_ff[1];

  // address classes; the two internal registers have fixed size, no stream
  wire is_cmd = (addr_ff < `SHCP_WR_BASE);
  wire is_rd = (addr_ff >= `SHCP_RD_BASE);
  wire is_mask = (addr_ff == `SHCP_ADDR_IRQ_MASK);
  wire is_stat = (addr_ff == `SHCP_ADDR_STATUS);
  wire internal = is_mask | is_stat;
  wire [1:0] dec_nb = internal ? 2'h1 : core_nbytes;
  wire dec_stream = internal ? 1'b0 : core_stream;
  wire [4:0] last_bit = {nb_ff, 3'h7};

  // read source, left-aligned so the top bit goes out first
  // [RULE_20] msb of the word leads
  wire [31:0] rd_src = is_stat ? {16'h0000, status_ff} : core_rd_data;
  wire [4:0] rd_sh = {~dec_nb, 3'h0};
  wire [4:0] rd_sh_cur = {~nb_ff, 3'h0};
  wire [31:0] rd_load = rd_src << rd_sh;
  wire [31:0] rd_load_cur = rd_src << rd_sh_cur;

  // word completion strobes
  wire word_end = sclk_rise & (bitcnt_ff == last_bit);
  wire wr_done = (state_ff == SHCP_WDATA) & word_end;
  wire [31:0] wr_word = {shift_ff[30:0], cbit};
  wire rd_done = (state_ff == SHCP_RDATA) & word_end;
  wire dec_cmd = (state_ff == SHCP_DECODE) & is_cmd;
  wire dec_rd = (state_ff == SHCP_DECODE) & is_rd;
  wire rd_reload = (state_ff == SHCP_RDATA) & sclk_fall & rose_ff & done_ff;

  // write hand-off toward the FIFO; a second word while one waits is lost
  wire push_wr = wr_done & ~is_mask;
  wire pend_go = pend_valid_ff & fifo_in_ready;
  wire overrun = push_wr & pend_valid_ff & ~fifo_in_ready;
  wire late_ev = (lat_cnt_ff == 12'(`SHCP_WR_LAT_CYC - 1));

  // status: events set, a completed status read clears what it reported
  wire [15:0] ev_all = status_event
    | (16'(overrun) << `SHCP_ST_OVERRUN) | (16'(late_ev) << `SHCP_ST_LATE);
  wire [15:0] st_clr = (rd_done && is_stat && !stream_ff) ? snap_ff : 16'h0000;
  wire [15:0] nxt_status = (status_ff & ~st_clr) | ev_all;

  // two-stage synchronisers on every pin input
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      sclk_s_ff <= 3'h0;
      cdat_s_ff <= 2'h0;
      sel_s_ff <= 3'h7;
    end
    else
    begin
      sclk_s_ff <= {sclk_s_ff[1:0], sclk};
      cdat_s_ff <= {cdat_s_ff[0], host_command_line};
      sel_s_ff <= {sel_s_ff[1:0], select_n};
    end
  end

  // transaction sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shift = shift_ff;
    nxt_addr = addr_ff;
    nxt_nb = nb_ff;
    nxt_stream = stream_ff;
    nxt_rose = rose_ff;
    nxt_done = done_ff;
    // [RULE_06] select high ends it
    if (!sel_low)
    begin
      nxt_state = SHCP_IDLE;
      nxt_bitcnt = 5'h00;
      nxt_rose = 1'b0;
      nxt_done = 1'b0;
    end
    else
    begin
      case (state_ff)
        // [RULE_12] only rising edges inside select count
        SHCP_IDLE:
        begin
          nxt_state = SHCP_ADDR;
          nxt_bitcnt = 5'h00;
        end
        // [RULE_01] one address byte
        SHCP_ADDR:
        begin
          if (sclk_rise)
          begin
            // [RULE_04] rising edge sample, msb first
            nxt_shift = {shift_ff[30:0], cbit};
            nxt_bitcnt = bitcnt_ff + 5'h01;
            if (bitcnt_ff == 5'h07)
            begin
              nxt_addr = {shift_ff[6:0], cbit};
              nxt_state = SHCP_DECODE;
            end
          end
        end
        // [RULE_11] direction from address
        SHCP_DECODE:
        begin
          nxt_bitcnt = 5'h00;
          // [RULE_02] bytes per word
          nxt_nb = dec_nb;
          // [RULE_08] streaming per register
          nxt_stream = dec_stream;
          nxt_rose = 1'b0;
          nxt_done = 1'b0;
          if (is_cmd)
            nxt_state = SHCP_SKIP;
          else if (is_rd)
          begin
            nxt_shift = rd_load;
            nxt_state = SHCP_RDATA;
          end
          else
          begin
            // clear the address bits so written words arrive right-aligned
            nxt_shift = 32'h0000_0000;
            nxt_state = SHCP_WDATA;
          end
        end
        // [RULE_13] bytes may stall or abut
        SHCP_WDATA:
        begin
          if (sclk_rise)
          begin
            nxt_shift = wr_word;
            nxt_bitcnt = bitcnt_ff + 5'h01;
            // [RULE_10] fixed-length word
            if (word_end)
            begin
              nxt_bitcnt = 5'h00;
              // a streamed word must not carry bits of the one before
              nxt_shift = 32'h0000_0000;
              nxt_state = stream_ff ? SHCP_WDATA : SHCP_SKIP;
            end
          end
        end
        // [RULE_05] shift only on falling edges
        SHCP_RDATA:
        begin
          if (sclk_rise)
          begin
            nxt_rose = 1'b1;
            nxt_bitcnt = bitcnt_ff + 5'h01;
            if (word_end)
            begin
              nxt_bitcnt = 5'h00;
              nxt_done = 1'b1;
            end
          end
          else if (sclk_fall && rose_ff)
          begin
            nxt_rose = 1'b0;
            nxt_done = 1'b0;
            nxt_shift = {shift_ff[30:0], 1'b0};
            if (done_ff)
            begin
              nxt_shift = rd_load_cur;
              nxt_state = stream_ff ? SHCP_RDATA : SHCP_SKIP;
            end
          end
        end
        // extra bits until select rises are ignored
        SHCP_SKIP:
          nxt_state = SHCP_SKIP;
        default:
          nxt_state = SHCP_IDLE;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_ff <= SHCP_IDLE;
      bitcnt_ff <= 5'h00;
      shift_ff <= 32'h0000_0000;
      addr_ff <= 8'h00;
      nb_ff <= 2'h0;
      stream_ff <= 1'b0;
      rose_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
      shift_ff <= nxt_shift;
      addr_ff <= nxt_addr;
      nb_ff <= nxt_nb;
      stream_ff <= nxt_stream;
      rose_ff <= nxt_rose;
      done_ff <= nxt_done;
    end
  end

  // reply pin; a single read ends on its word boundary, a stream read only on select
  // [RULE_19] driven in read data only
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      reply_ff <= 1'b0;
      reply_oe_n_ff <= 1'b1;
    end
    else
    begin
      reply_ff <= nxt_shift[31];
      reply_oe_n_ff <= ~(sel_low && nxt_state == SHCP_RDATA);
    end
  end

  // command pulses and core read pops
  // [RULE_03] act at address end
  // [RULE_09] code 01 resets the device
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cmd_valid_ff <= 1'b0;
      cmd_code_ff <= 8'h00;
      dev_reset_ff <= 1'b0;
      take_ff <= 1'b0;
    end
    else
    begin
      cmd_valid_ff <= dec_cmd;
      if (dec_cmd)
        cmd_code_ff <= addr_ff;
      dev_reset_ff <= dec_cmd & (addr_ff == `SHCP_ADDR_RESET);
      take_ff <= ((dec_rd && sel_low) || (rd_reload && sel_low && stream_ff)) && !internal;
    end
  end

  // single word holding stage ahead of the FIFO
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pend_valid_ff <= 1'b0;
      pend_ff <= '0;
    end
    else if (push_wr && (!pend_valid_ff || fifo_in_ready))
    begin
      pend_valid_ff <= 1'b1;
      pend_ff <= '{addr: addr_ff, data: wr_word};
    end
    else if (pend_go)
      pend_valid_ff <= 1'b0;
  end

  // [RULE_08] write words through FIFO
  shcp_fifo #(
    .W($bits(shcp_word_s)),
    .D(4)
  ) u_wr_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(pend_ff),
    .in_valid(pend_valid_ff),
    .in_ready(fifo_in_ready),
    .out_data(core_wr_word),
    .out_valid(core_wr_valid),
    .out_ready(core_wr_ready)
  );

  // [RULE_07] flag a word left waiting past the pickup budget
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      lat_cnt_ff <= 12'h000;
    else if (core_wr_valid && !core_wr_ready && !late_ev)
      lat_cnt_ff <= lat_cnt_ff + 12'h001;
    else if (!(core_wr_valid && !core_wr_ready))
      lat_cnt_ff <= 12'h000;
  end

  // [RULE_17] mask and status registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      mask_ff <= `SHCP_MASK_RESET;
      status_ff <= `SHCP_STATUS_RESET;
      snap_ff <= 16'h0000;
    end
    else
    begin
      if (wr_done && is_mask)
        mask_ff <= wr_word[15:0];
      // set wins over the read clear
      status_ff <= nxt_status;
      if (dec_rd && is_stat)
        snap_ff <= status_ff;
    end
  end

  // [RULE_14] masked interrupt
  // [RULE_15] raise on enabled status
  // [RULE_18] open drain, active low
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq_n_ff <= 1'b1;
    else
      irq_n_ff <= ~|(nxt_status & mask_ff);
  end

  assign reply_data = reply_ff;
  assign reply_oe_n = reply_oe_n_ff;
  assign irq_request_n = irq_n_ff;
  assign irq_oe_n = irq_n_ff;
  assign core_addr = addr_ff;
  assign core_rd_take = take_ff;
  assign cmd_code = cmd_code_ff;
  assign cmd_valid = cmd_valid_ff;
  assign dev_reset = dev_reset_ff;
endmodule : shcp_port

// file: hw/shcp_cfg.svh
// Purpose: constants for the serial host command port
// Assumes: 10 MHz core clock
// Notes: offsets are the serial address bytes of the register map
`ifndef SHCP_CFG_SVH
`define SHCP_CFG_SVH
`define SHCP_ADDR_RESET 8'h01
`define SHCP_ADDR_IRQ_MASK 8'h1F
`define SHCP_ADDR_STATUS 8'h40
`define SHCP_WR_BASE 8'h10
`define SHCP_RD_BASE 8'h40
`define SHCP_MASK_RESET 16'h0000
`define SHCP_STATUS_RESET 16'h0000
`define SHCP_ST_OVERRUN 15
`define SHCP_ST_LATE 14
`define SHCP_CLK_MHZ 10
`define SHCP_WR_LAT_US 60
`define SHCP_WR_LAT_CYC (`SHCP_WR_LAT_US * `SHCP_CLK_MHZ)
`endif

// file: hw/shcp_pkg.sv
// Purpose: types shared by the serial host command port
// Assumes: nothing beyond the cfg header
// Notes: words are carried right-aligned in the data field
package shcp_pkg;
  typedef enum logic [2:0] {
    SHCP_IDLE, SHCP_ADDR, SHCP_DECODE, SHCP_WDATA, SHCP_RDATA, SHCP_SKIP
  } shcp_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
  } shcp_word_s;
endpackage : shcp_pkg

// file: hw/shcp_fifo.sv
// Purpose: small synchronous FIFO for written words
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty come from an occupancy count
`timescale 1ns/100ps
module shcp_fifo #(
  parameter int W = 40,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] nxt_wp = (wp_ff == AW'(D - 1)) ? '0 : wp_ff + 1'b1;
  wire [AW-1:0] nxt_rp = (rp_ff == AW'(D - 1)) ? '0 : rp_ff + 1'b1;
  assign in_ready = (cnt_ff != (AW + 1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rp_ff];
  // storage carries no reset, only pointers and count do
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data;
  end
  // pointers and occupancy
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= nxt_wp;
      if (pop)
        rp_ff <= nxt_rp;
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end
endmodule : shcp_fifo

// file: test/shcp_host.sv
// Purpose: host model driving the serial pins of the command port
// Assumes: clk is the device clock; serial clock half period 4 clk
// Notes: pins change 1 ns after a clk edge
`timescale 1ns/100ps
module shcp_host (
  input wire logic clk,
  input wire logic rpin,
  output logic sclk,
  output logic host_command_line,
  output logic select_n
);
  logic idl;
  // deselected, clock parked
  initial
  begin
    sclk = 1'b0;
    host_command_line = 1'b0;
    select_n = 1'b1;
    idl = 1'b0;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk
  task automatic open(input logic lv);
    tk(1);
    idl = lv;
    sclk = lv;
    select_n = 1'b0;
    tk(4);
  endtask : open
  task automatic xf(input logic [7:0] tx, input logic dr, input int gap,
                    output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b0;
      host_command_line = dr ? tx[i] : ~host_command_line;
      tk(4);
      sclk = 1'b1;
      tk(4);
      rx[i] = rpin;
    end
    tk(gap);
  endtask : xf
  task automatic close();
    sclk = idl;
    tk(4);
    select_n = 1'b1;
    host_command_line = ~host_command_line;
    tk(8);
  endtask : close
endmodule : shcp_host

// file: test/shcp_port_chk.sv
// Purpose: pin-level checker for the command port
// Assumes: one clock domain, bench pins move off the edge
// Notes: bound below to every port instance
`timescale 1ns/100ps
module shcp_port_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sclk,
  input wire logic select_n,
  input wire logic reply_data,
  input wire logic reply_oe_n,
  input wire logic irq_request_n,
  input wire shcp_pkg::shcp_word_s core_wr_word,
  input wire logic core_wr_valid,
  input wire logic core_wr_ready,
  input wire logic [7:0] core_addr,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_valid,
  input wire logic dev_reset
);
  import shcp_pkg::*;
  logic mask_seen_ff;
  logic nxt_mask_seen;
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // mask cannot enable anything before it is addressed
  assign nxt_mask_seen = mask_seen_ff | (core_addr == 8'h1F);
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      mask_seen_ff <= 1'b0;
    else
      mask_seen_ff <= nxt_mask_seen;
  end
  // a whole driven high phase of the serial clock
  sequence s_hi_drive;
    (sclk && !reply_oe_n) [*4];
  endsequence
  AST_REPLY_HOLD: assert property (s_hi_drive |-> $stable(reply_data))
    else $error("reply bit moved in high phase");
  AST_SEL_END: assert property ($rose(select_n) |-> ##[1:6] reply_oe_n)
    else $error("reply still driven after select");
  AST_OE_SEL: assert property ($fell(reply_oe_n) |-> !select_n && !$past(select_n, 4))
    else $error("reply driven outside a frame");
  AST_OE_DIR: assert property (!reply_oe_n |-> core_addr >= 8'h40)
    else $error("reply driven for a non-read");
  AST_CMD_RST: assert property (dev_reset == (cmd_valid && cmd_code == 8'h01))
    else $error("reset pulse mismatch");
  AST_CMD_CLASS: assert property (cmd_valid |-> core_addr == cmd_code && cmd_code < 8'h10)
    else $error("command outside command range");
  AST_WR_HOLD: assert property (core_wr_valid && !core_wr_ready |=>
    core_wr_valid && $stable(core_wr_word))
    else $error("write word lost while stalled");
  AST_IRQ_MASK: assert property (!mask_seen_ff |-> irq_request_n)
    else $error("interrupt with empty mask");
endmodule : shcp_port_chk
bind shcp_port shcp_port_chk u_chk (
  .clk(clk),
  .rst_b(rst_b),
  .sclk(sclk),
  .select_n(select_n),
  .reply_data(reply_data),
  .reply_oe_n(reply_oe_n),
  .irq_request_n(irq_request_n),
  .core_wr_word(core_wr_word),
  .core_wr_valid(core_wr_valid),
  .core_wr_ready(core_wr_ready),
  .core_addr(core_addr),
  .cmd_code(cmd_code),
  .cmd_valid(cmd_valid),
  .dev_reset(dev_reset)
);

// file: test/shcp_port_tb.sv
// Purpose: self-checking bench for the command port
// Assumes: host model owns the serial pins
// Notes: core side is modelled here
`timescale 1ns/100ps
module shcp_port_tb;
  import shcp_pkg::*;
  logic clk, rst_b, sclk, host_command_line, select_n, reply_data, reply_oe_n;
  logic irq_request_n, irq_oe_n, core_wr_valid, core_wr_ready, core_stream;
  logic core_rd_take, cmd_valid, dev_reset, rpin, irq_pin;
  logic rlast = 1'b0;
  shcp_word_s core_wr_word;
  logic [7:0] core_addr, cmd_code, cmd_last;
  logic [1:0] core_nbytes;
  logic [31:0] core_rd_data;
  logic [15:0] status_event;
  int n_cmd = 0;
  int n_rst = 0;
  int n_errors = 0;
  int total_checks = 0;
  shcp_port DUT (
    .clk(clk),
    .rst_b(rst_b),
    .sclk(sclk),
    .host_command_line(host_command_line),
    .select_n(select_n),
    .reply_data(reply_data),
    .reply_oe_n(reply_oe_n),
    .irq_request_n(irq_request_n),
    .irq_oe_n(irq_oe_n),
    .core_wr_word(core_wr_word),
    .core_wr_valid(core_wr_valid),
    .core_wr_ready(core_wr_ready),
    .core_addr(core_addr),
    .core_nbytes(core_nbytes),
    .core_stream(core_stream),
    .core_rd_data(core_rd_data),
    .core_rd_take(core_rd_take),
    .cmd_code(cmd_code),
    .cmd_valid(cmd_valid),
    .dev_reset(dev_reset),
    .status_event(status_event)
  );
  shcp_host host (
    .clk(clk),
    .rpin(rpin),
    .sclk(sclk),
    .host_command_line(host_command_line),
    .select_n(select_n)
  );
  // released reply line shows the inverse of its last bit; irq has a pull-up
  assign rpin = reply_oe_n ? ~rlast : reply_data;
  assign irq_pin = irq_oe_n ? 1'b1 : 1'b0;
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // watch pins between edges so no race with the design
  always @(negedge clk)
  begin
    if (!reply_oe_n)
      rlast = reply_data;
    if (cmd_valid === 1'b1)
    begin
      n_cmd++;
      cmd_last = cmd_code;
      n_rst += (dev_reset === 1'b1);
    end
  end
  // core hands over the next stream word after each take
  always @(posedge clk)
  begin
    if (core_rd_take === 1'b1)
      core_rd_data <= #1 core_rd_data + 32'h1;
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd16(input logic [7:0] a, input logic lv, output logic [15:0] v);
    logic [7:0] b;
    host.open(lv);
    host.xf(a, 1'b1, 0, b);
    host.xf(8'h00, 1'b0, 0, v[15:8]);
    host.xf(8'h00, 1'b0, 0, v[7:0]);
    host.close();
  endtask : rd16
  task automatic evt(input logic [15:0] e);
    status_event = e;
    host.tk(1);
    status_event = 16'h0;
    host.tk(3);
  endtask : evt
  task automatic t_cmd();
    logic [7:0] b;
    chk(reply_oe_n, 1'b1);
    chk(irq_pin, 1'b1);
    host.open(1'b0);
    host.xf(8'h01, 1'b1, 0, b);
    host.xf(8'h02, 1'b1, 0, b);
    host.close();
    host.open(1'b1);
    host.xf(8'h07, 1'b1, 9, b);
    host.close();
    chk(n_cmd, 2);
    chk(n_rst, 1);
    chk(cmd_last, 8'h07);
  endtask : t_cmd
  task automatic t_irq();
    logic [7:0] b;
    logic [15:0] v;
    evt(16'h0004);
    chk(irq_pin, 1'b1);
    host.open(1'b1);
    host.xf(8'h1F, 1'b1, 0, b);
    host.xf(8'h00, 1'b1, 7, b);
    host.xf(8'h04, 1'b1, 0, b);
    host.close();
    chk(irq_pin, 1'b0);
    evt(16'h0020);
    rd16(8'h40, 1'b0, v);
    chk(v, 16'h0024);
    chk(irq_pin, 1'b1);
    rd16(8'h40, 1'b1, v);
    chk(v, 16'h0000);
  endtask : t_irq
  task automatic t_fifo();
    logic [7:0] b;
    logic [15:0] v;
    int w;
    core_wr_ready = 1'b0;
    core_nbytes = 2'h1;
    core_stream = 1'b1;
    host.open(1'b0);
    host.xf(8'h22, 1'b1, 0, b);
    for (int k = 0; k < 6; k++)
    begin
      host.xf(8'h5A, 1'b1, k * 5, b);
      host.xf(k[7:0], 1'b1, 0, b);
    end
    host.close();
    core_stream = 1'b0;
    rd16(8'h40, 1'b0, v);
    chk(v, 16'hC000);
    for (int k = 0; k < 5; k++)
    begin
      w = 0;
      while (core_wr_valid !== 1'b1 && w < 20)
      begin
        host.tk(1);
        w++;
      end
      chk(core_wr_word, {8'h22, 24'h00005A, k[7:0]});
      core_wr_ready = 1'b1;
      host.tk(1);
      core_wr_ready = 1'b0;
      host.tk(1);
    end
    chk(core_wr_valid, 1'b0);
  endtask : t_fifo
  task automatic t_read();
    logic [7:0] b;
    logic [15:0] v;
    core_nbytes = 2'h0;
    core_rd_data = 32'hA5C37E81;
    host.open(1'b1);
    host.xf(8'h50, 1'b1, 0, b);
    host.xf(8'h00, 1'b0, 0, b);
    chk(b, 8'h81);
    host.xf(8'h00, 1'b0, 0, b);
    chk(reply_oe_n, 1'b1);
    host.close();
    core_nbytes = 2'h1;
    core_stream = 1'b1;
    core_rd_data = 32'h00000100;
    host.open(1'b0);
    host.xf(8'h60, 1'b1, 0, b);
    for (int k = 0; k < 2; k++)
    begin
      host.xf(8'h00, 1'b0, 0, v[15:8]);
      host.xf(8'h00, 1'b0, 3, v[7:0]);
      chk(v, 16'h0100 + k);
    end
    host.close();
  endtask : t_read
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // hang guard: the tests need under 10000 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end
  initial
  begin
    rst_b = 1'b0;
    core_wr_ready = 1'b0;
    core_stream = 1'b0;
    core_nbytes = 2'h0;
    core_rd_data = 32'h0000_0000;
    status_event = 16'h0000;
    host.tk(6);
    rst_b = 1'b1;
    host.tk(4);
    t_cmd();
    t_irq();
    t_fifo();
    t_read();
    tally_and_finish();
  end
endmodule : shcp_port_tb
